// File: include/apc_pkg.sv
/*
 * Shared constants and types for the analog output calibration panel.
 * Assumes a 200 MHz module clock and a 32-bit AXI4-Lite register bus.
 */
package apc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
	localparam int unsigned LED_SLOW_MS = 500;  // Calibrate blink half period
	localparam int unsigned LED_FAST_MS = 100;  // Out-of-range blink
	localparam int unsigned HOLD_MS     = 1500; // Hold before auto-repeat
	localparam int unsigned REPEAT_MS   = 20;   // Auto-repeat step period
	localparam int unsigned SLOW_CYC    = LED_SLOW_MS * CYC_PER_MS;
	localparam int unsigned FAST_CYC    = LED_FAST_MS * CYC_PER_MS;
	localparam int unsigned HOLD_CYC    = HOLD_MS * CYC_PER_MS;
	localparam int unsigned REPEAT_CYC  = REPEAT_MS * CYC_PER_MS;
	localparam int unsigned CNT_W       = 32;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
	localparam logic [7:0]  REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0]  REG_CAL_IDX  = 8'h10;
	localparam logic [7:0]  REG_CAL_DATA = 8'h14;
	localparam int unsigned CTRL_HOST_STOP = 0;
	localparam int unsigned CTRL_DATA_ERR  = 1;
	localparam int unsigned CTRL_W         = 2;
	localparam int unsigned IRQ_STEP    = 0;
	localparam int unsigned IRQ_STORE   = 1;
	localparam int unsigned IRQ_REFUSE  = 2;
	localparam int unsigned IRQ_MODE    = 3;
	localparam int unsigned IRQ_W       = 4;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Calibration store
	// ----------------------------------------------------------------
	localparam int unsigned CH_NUM   = 8;
	localparam int unsigned VAL_W    = 16;
	localparam logic [3:0]  SEL_FIRST = 4'h1;
	localparam logic [3:0]  SEL_LAST  = 4'h8;
	localparam logic [15:0] OFS_RST  = 16'h0000;
	localparam logic [15:0] GAIN_RST = 16'h7000;

	typedef enum logic [1:0] {
		CAL_STORE  = 2'b00,
		CAL_OFFSET = 2'b01,
		CAL_GAIN   = 2'b10
	} apc_cal_pos_t;

	typedef struct packed {
		logic       test_short;
		logic [3:0] chan_sel;
		logic [1:0] cal_pos;
		logic       step_up;
		logic       step_down;
	} apc_panel_t;

	typedef struct packed {
		logic watchdog_expiry;
		logic hw_fault;
	} apc_fault_t;

endpackage

// File: hw/apc_blinker.sv
/*
 * Free-running square wave used for the status LED blink patterns.
 * Assumes one clock; HALF_CYC is at least one.
 */
`timescale 1ns/10ps
module apc_blinker
	import apc_pkg::*;
#(
	parameter int unsigned HALF_CYC = SLOW_CYC
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Wave out
	output logic      wave
);

	logic [CNT_W-1:0] cnt_q;
	logic             wave_q;

	// Toggle once per half period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= '0;
			wave_q <= 1'b0;
		end else if (cnt_q == CNT_W'(HALF_CYC - 1)) begin
			cnt_q  <= '0;
			wave_q <= ~wave_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign wave = wave_q;

endmodule // apc_blinker

// File: hw/apc_step_repeat.sv
/*
 * Up/down switch stepper: one step on press, auto-repeat after a hold.
 * Assumes switch levels already synchronous and debounced.
 */
`timescale 1ns/10ps
module apc_step_repeat
	import apc_pkg::*;
#(
	parameter int unsigned HOLD_CYC_P   = HOLD_CYC,
	parameter int unsigned REPEAT_CYC_P = REPEAT_CYC
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Switch levels
	input  wire logic up,
	input  wire logic down,
	// Step pulse and direction
	output logic      step,
	output logic      step_up
);

	logic             press;
	logic             held_q;
	logic             rep_q;
	logic             step_q;
	logic             dir_q;
	logic [CNT_W-1:0] cnt_q;
	logic             rep_due;

	// Both positions at once is treated as released
	assign press   = up ^ down;
	assign rep_due = rep_q && (cnt_q == CNT_W'(REPEAT_CYC_P - 1));

	// Hold timing: first hold phase, then repeat phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_q <= 1'b0;
			rep_q  <= 1'b0;
			cnt_q  <= '0;
		end else if (!press) begin
			held_q <= 1'b0;
			rep_q  <= 1'b0;
			cnt_q  <= '0;
		end else if (!held_q) begin
			held_q <= 1'b1;
			cnt_q  <= '0;
		end else if (!rep_q) begin
			if (cnt_q == CNT_W'(HOLD_CYC_P - 1)) begin
				rep_q <= 1'b1;
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end else if (rep_due) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// One step at press, then one per repeat period once the hold phase has passed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_q <= 1'b0;
			dir_q  <= 1'b0;
		end else begin
			step_q <= press && (!held_q || rep_due);
			dir_q  <= up;
		end
	end

	assign step    = step_q;
	assign step_up = dir_q;

endmodule // apc_step_repeat

// File: hw/apc_cal_panel.sv
/*
 * Front-panel control of an eight-channel analog output module: mode
 * strap, channel and calibration selectors, up/down stepping, stored
 * offset/gain pairs, status LED patterns and an AXI4-Lite slave.
 * Assumes all panel inputs are synchronous and debounced upstream.
 */
// The AXI4-Lite register port and the register offsets are this design's own decisions.
// How it works
// - Normal mode: LED off on watchdog expiry, hardware fault or host stop.
// - Normal mode: LED blinks while a host write data error is flagged.
// - Test mode at offset or gain position: LED toggles every half second.
// - Test mode: LED blinks every 0.1 s when offset exceeds gain.
// - Test mode at store position: LED held off.
// - Channel selector taken only in test mode; positions 0 and 9 ignored.
// - Calibration selector means adjust offset, adjust gain, or store.
// - Leaving offset or gain for store writes the value for that channel.
// - Short press of up/down moves the value by exactly one step.
// - Press held 1.5 s or longer repeats a step every 20 ms.
// - Open test terminals select normal output mode.
// - Shorted test terminals select test mode for calibration.
// - Test mode halts conversion; normal mode resumes with stored values.
// - No store while the out-of-range fast blink is active.
`timescale 1ns/10ps
module apc_cal_panel
	import apc_pkg::*;
#(
	parameter int unsigned SLOW_CYC_P   = SLOW_CYC,
	parameter int unsigned FAST_CYC_P   = FAST_CYC,
	parameter int unsigned HOLD_CYC_P   = HOLD_CYC,
	parameter int unsigned REPEAT_CYC_P = REPEAT_CYC
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data and response
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Front panel and fault inputs
	input  wire apc_panel_t        panel,
	input  wire apc_fault_t        fault,
	// Panel and system outputs
	output logic                   status_led,
	output logic                   conv_enable,
	output logic                   irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int unsigned IDX_W = $clog2(CH_NUM);

	logic               test_q;
	apc_cal_pos_t       pos_q;
	apc_cal_pos_t       pos_now;
	logic [IDX_W-1:0]   chan_q;
	logic [VAL_W-1:0]   ofs_q  [CH_NUM];
	logic [VAL_W-1:0]   gain_q [CH_NUM];
	logic [VAL_W-1:0]   wk_q;
	logic               adjusting;
	logic               enter_adj;
	logic               to_store;
	logic               fast;
	logic               step;
	logic               step_up;
	logic               slow_wave;
	logic               fast_wave;
	logic               led_q;
	logic               conv_q;
	logic [CTRL_W-1:0]  ctrl_q;
	logic [IRQ_W-1:0]   irq_stat_q;
	logic [IRQ_W-1:0]   irq_mask_q;
	logic [IRQ_W-1:0]   irq_ev;
	logic [IDX_W-1:0]   cal_idx_q;
	logic [ADDR_W-1:0]  awaddr_q;
	logic               aw_have_q;
	logic [31:0]        wdata_q;
	logic               w_have_q;
	logic               wstrb0_q;
	logic               bvalid_q;
	logic [1:0]         bresp_q;
	logic               rvalid_q;
	logic [31:0]        rdata_q;
	logic [1:0]         rresp_q;
	logic               wr_fire;
	logic               wr_en;

	// Step value by one count, saturating at the signed limits
	function automatic logic [VAL_W-1:0] step_val(
		input logic [VAL_W-1:0] v,
		input logic             up
	);
		logic [VAL_W-1:0] vmax;
		logic [VAL_W-1:0] vmin;
		vmax = {1'b0, {(VAL_W-1){1'b1}}};
		vmin = {1'b1, {(VAL_W-1){1'b0}}};
		if (up) begin
			step_val = (v == vmax) ? v : v + 1'b1;
		end else begin
			step_val = (v == vmin) ? v : v - 1'b1;
		end
	endfunction

	// Signed compare: a greater than b
	function automatic logic sgt(
		input logic [VAL_W-1:0] a,
		input logic [VAL_W-1:0] b
	);
		sgt = $signed(a) > $signed(b);
	endfunction

	// ----------------------------------------------------------------
	// Mode and selector decode
	// ----------------------------------------------------------------
	// Illegal selector code reads as store: the safe, no-adjust position
	always_comb begin
		unique case (panel.cal_pos)
			CAL_OFFSET: pos_now = CAL_OFFSET;
			CAL_GAIN:   pos_now = CAL_GAIN;
			default:    pos_now = CAL_STORE;
		endcase
	end

	assign adjusting = test_q && (pos_q != CAL_STORE);
	assign enter_adj = test_q && (pos_now != pos_q)
		&& (pos_now != CAL_STORE);
	assign to_store  = adjusting && (pos_now == CAL_STORE);

	// Out of range when offset passes gain: working offset vs stored gain, or stored offset vs working gain
	always_comb begin
		unique case (pos_q)
			CAL_OFFSET: fast = test_q && sgt(wk_q, gain_q[chan_q]);
			CAL_GAIN:   fast = test_q && sgt(ofs_q[chan_q], wk_q);
			default:    fast = 1'b0;
		endcase
	end

	// Strap level: shorted means test mode, open means normal
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_q <= 1'b0;
		end else begin
			test_q <= panel.test_short;
		end
	end

	// Previous selector position; forced to store outside test mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_q <= CAL_STORE;
		end else if (!test_q) begin
			pos_q <= CAL_STORE;
		end else begin
			pos_q <= pos_now;
		end
	end

	// Channel latch, test mode only, positions 1..8 only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_q <= '0;
		end else if (test_q && panel.chan_sel >= SEL_FIRST
				&& panel.chan_sel <= SEL_LAST) begin
			chan_q <= IDX_W'(panel.chan_sel - SEL_FIRST);
		end
	end

	// ----------------------------------------------------------------
	// Stepping and working value
	// ----------------------------------------------------------------
	apc_step_repeat #(
		.HOLD_CYC_P   (HOLD_CYC_P),
		.REPEAT_CYC_P (REPEAT_CYC_P)
	) u_step (
		.aclk    (aclk),
		.aresetn (aresetn),
		.up      (panel.step_up),
		.down    (panel.step_down),
		.step    (step),
		.step_up (step_up)
	);

	// Load from the store on entering a position, then step it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wk_q <= OFS_RST;
		end else if (enter_adj) begin
			wk_q <= (pos_now == CAL_OFFSET) ? ofs_q[chan_q]
				: gain_q[chan_q];
		end else if (adjusting && step) begin
			wk_q <= step_val(wk_q, step_up);
		end
	end

	// Commit on move to store, refused while out of range
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < CH_NUM; i++) begin
				ofs_q[i]  <= OFS_RST;
				gain_q[i] <= GAIN_RST;
			end
		end else if (to_store && !fast) begin
			if (pos_q == CAL_OFFSET) begin
				ofs_q[chan_q] <= wk_q;
			end else begin
				gain_q[chan_q] <= wk_q;
			end
		end
	end

	// Conversion stops in test mode, resumes with stored pair after
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_q <= 1'b0;
		end else begin
			conv_q <= !test_q;
		end
	end

	// ----------------------------------------------------------------
	// Status LED
	// ----------------------------------------------------------------
	apc_blinker #(
		.HALF_CYC (SLOW_CYC_P)
	) u_slow (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wave    (slow_wave)
	);

	apc_blinker #(
		.HALF_CYC (FAST_CYC_P)
	) u_fast (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wave    (fast_wave)
	);

	// In normal mode fault wins over blink so a dead module never looks alive; test mode ignores faults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			led_q <= 1'b0;
		end else if (!test_q) begin
			if (fault.watchdog_expiry || fault.hw_fault
					|| ctrl_q[CTRL_HOST_STOP]) begin
				led_q <= 1'b0;
			end else if (ctrl_q[CTRL_DATA_ERR]) begin
				led_q <= slow_wave;
			end else begin
				led_q <= 1'b1;
			end
		end else if (pos_q == CAL_STORE) begin
			led_q <= 1'b0;
		end else if (fast) begin
			led_q <= fast_wave;
		end else begin
			led_q <= slow_wave;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_ev[IRQ_STEP]   = adjusting && step;
	assign irq_ev[IRQ_STORE]  = to_store && !fast;
	assign irq_ev[IRQ_REFUSE] = to_store && fast;
	assign irq_ev[IRQ_MODE]   = test_q != panel.test_short;

	// Write one to clear; a new event in the same cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
		end else if (wr_en && awaddr_q == REG_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~wdata_q[IRQ_W-1:0]) | irq_ev;
		end else begin
			irq_stat_q <= irq_stat_q | irq_ev;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Address and data taken in either order, response after both
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_en   = wr_fire && wstrb0_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wdata_q  <= '0;
			wstrb0_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb0_q <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	// Write response; all fields sit in byte lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			unique case (awaddr_q)
				REG_CTRL, REG_IRQ_STAT, REG_IRQ_MASK, REG_CAL_IDX:
					bresp_q <= RESP_OKAY;
				default: bresp_q <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Software-written control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q     <= '0;
			irq_mask_q <= '0;
			cal_idx_q  <= '0;
		end else if (wr_en) begin
			if (awaddr_q == REG_CTRL) begin
				ctrl_q <= wdata_q[CTRL_W-1:0];
			end
			if (awaddr_q == REG_IRQ_MASK) begin
				irq_mask_q <= wdata_q[IRQ_W-1:0];
			end
			if (awaddr_q == REG_CAL_IDX) begin
				cal_idx_q <= wdata_q[IDX_W-1:0];
			end
		end
	end

	// Read path: one word per access, answered the cycle after
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
			unique case (s_axi_araddr)
				REG_CTRL:     rdata_q[CTRL_W-1:0] <= ctrl_q;
				REG_STATUS:   rdata_q[7:0] <= {led_q, fast, chan_q,
					pos_q, test_q};
				REG_IRQ_STAT: rdata_q[IRQ_W-1:0] <= irq_stat_q;
				REG_IRQ_MASK: rdata_q[IRQ_W-1:0] <= irq_mask_q;
				REG_CAL_IDX:  rdata_q[IDX_W-1:0] <= cal_idx_q;
				REG_CAL_DATA: rdata_q <= {gain_q[cal_idx_q],
					ofs_q[cal_idx_q]};
				default:      rresp_q <= RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign status_led    = led_q;
	assign conv_enable   = conv_q;
	assign irq           = |(irq_stat_q & irq_mask_q);

endmodule // apc_cal_panel

// File: sim/apc_monitor.sv
/* Concurrent checks on the calibration panel top ports.
   Assumes one clock, sync active-low reset, bound to the top module. */
`timescale 1ns/10ps
module apc_monitor
	import apc_pkg::*;
#(
	parameter int unsigned SLOW_CYC_P = SLOW_CYC
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Panel side
	input wire apc_panel_t  panel,
	input wire apc_fault_t  fault,
	input wire logic        status_led,
	input wire logic        conv_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// -------------------------------------------------------------
	// LED idle time while adjusting; a stuck LED shows as a long run
	// -------------------------------------------------------------
	logic        adj;
	logic [31:0] still_q;
	assign adj = panel.test_short && panel.cal_pos inside {CAL_OFFSET, CAL_GAIN};
	always_ff @(posedge aclk) begin
		if (!aresetn || !adj || status_led != $past(status_led))
			still_q <= '0;
		else
			still_q <= still_q + 32'h0000_0001;
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	property p_conv_test;
		panel.test_short |-> ##2 !conv_enable;
	endproperty
	a_conv_test: assert property (p_conv_test)
		else $error("conversion running in test mode");
	property p_conv_norm;
		!panel.test_short |-> ##2 conv_enable;
	endproperty
	a_conv_norm: assert property (p_conv_norm)
		else $error("conversion stopped in normal mode");
	property p_led_store;
		(panel.test_short && panel.cal_pos == CAL_STORE)[*4] |-> !status_led;
	endproperty
	a_led_store: assert property (p_led_store)
		else $error("LED lit at store position");
	property p_led_fault;
		(!panel.test_short && (fault.watchdog_expiry || fault.hw_fault))[*4]
			|-> !status_led;
	endproperty
	a_led_fault: assert property (p_led_fault)
		else $error("LED lit during a fault");
	property p_led_adj;
		still_q <= SLOW_CYC_P + 4;
	endproperty
	a_led_adj: assert property (p_led_adj)
		else $error("LED not toggling while adjusting");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_ar_take;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_ar_take: assert property (p_ar_take)
		else $error("read not answered next cycle");
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after)
		else $error("write response late");
endmodule // apc_monitor

bind apc_cal_panel apc_monitor #(.SLOW_CYC_P(SLOW_CYC_P)) u_mon (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .panel, .fault, .status_led, .conv_enable
);

// File: sim/apc_panel_model.sv
/* Operator and front-panel model: strap, selectors, up/down switch.
   Assumes the bench calls its tasks from the aclk domain. */
`timescale 1ns/10ps
module apc_panel_model
	import apc_pkg::*;
(
	// Clock
	input  wire logic  aclk,
	// Panel levels and LED
	output apc_panel_t panel,
	input  wire logic  status_led
);
	// Strap open, store, channel 1, switch released
	initial panel = {1'b0, SEL_FIRST, CAL_STORE, 2'b00};

	// Strap and selector moves, one edge each
	task automatic strap(input logic s);
		@(posedge aclk);
		panel.test_short <= s;
	endtask
	task automatic pos(input apc_cal_pos_t p);
		@(posedge aclk);
		panel.cal_pos <= p;
	endtask
	// Operator turns the channel knob only at store
	task automatic chan(input logic [3:0] c);
		@(posedge aclk);
		if (panel.cal_pos == CAL_STORE)
			panel.chan_sel <= c;
	endtask
	// Hold one direction for n cycles, then release
	task automatic press(input logic up, input int n);
		@(posedge aclk);
		{panel.step_up, panel.step_down} <= {up, !up};
		repeat (n) @(posedge aclk);
		{panel.step_up, panel.step_down} <= 2'b00;
	endtask
	// LED changes seen over n cycles
	task automatic toggles(input int n, output int t);
		logic l;
		t = 0;
		l = status_led;
		repeat (n) begin
			@(posedge aclk);
			if (status_led !== l)
				t++;
			l = status_led;
		end
	endtask
endmodule // apc_panel_model

// File: sim/apc_cal_panel_tb.sv
/* Self-checking bench for the calibration panel.
   Assumes shortened blink, hold and repeat counts on the top module. */
`timescale 1ns/10ps
module apc_cal_panel_tb
	import apc_pkg::*;
;
	localparam int HOLD = 50;
	localparam int REP  = 2;
	logic        aclk, aresetn, status_led, conv_enable, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, scratch;
	logic [1:0]  s_axi_bresp, s_axi_rresp, scratch_resp;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	apc_panel_t  panel;
	apc_fault_t  fault;
	int          failures, num_checks;

	// -------------------------------------------------------------
	// Design, panel model, clock
	// -------------------------------------------------------------
	apc_cal_panel #(.SLOW_CYC_P(10), .FAST_CYC_P(4), .HOLD_CYC_P(HOLD),
		.REPEAT_CYC_P(REP)) u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .panel,
		.fault, .status_led, .conv_enable, .irq
	);
	apc_panel_model u_pm (.aclk, .panel, .status_led);
	always #2.5 aclk = ~aclk;

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One AXI4-Lite transfer, a write when wr, else a read
	task automatic axi(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (wr ? s_axi_bvalid : s_axi_rvalid)
				break;
		end
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 50) begin
			failures++;
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi(1'b1, a, d, scratch, scratch_resp);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		axi(1'b0, a, 32'h0000_0000, q, scratch_resp);
	endtask

	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	// Reset contents and an unmapped address
	task automatic s_regs();
		logic [31:0] q;
		logic [1:0]  r;
		rd(REG_CAL_DATA, q);
		chk(q, {GAIN_RST, OFS_RST});
		axi(1'b0, 8'h40, 32'h0000_0000, q, r);
		chk({q[31:2], r}, {30'h0, RESP_SLVERR});
		s_axi_wstrb <= 4'hE;
		wr(REG_CTRL, 32'h0000_0003);
		s_axi_wstrb <= 4'hF;
	endtask
	// Normal mode: conversion, data-error blink, faults and host stop
	task automatic s_normal();
		logic [31:0] q;
		int          t, k;
		chk(32'(conv_enable), 32'h1);
		u_pm.chan(4'h5);
		rd(REG_STATUS, q);
		chk(32'(q[7:0]), 32'h0000_0080);
		wr(REG_CTRL, 32'h0000_0001 << CTRL_DATA_ERR);
		u_pm.toggles(40, t);
		chk(32'(t inside {[3:5]}), 32'h1);
		for (k = 0; k < 3; k++) begin
			@(posedge aclk);
			fault <= apc_fault_t'(2'b10 >> k);
			if (k == 2)
				wr(REG_CTRL, 32'h0000_0001 << CTRL_HOST_STOP);
			repeat (4) @(posedge aclk);
			u_pm.toggles(30, t);
			chk({31'(t), status_led}, 32'h0);
		end
		wr(REG_CTRL, 32'h0000_0000);
	endtask
	// Test mode: channel pick, blink, single and repeated steps, store
	task automatic s_test();
		logic [31:0] q, p;
		int          t;
		u_pm.strap(1'b1);
		repeat (4) @(posedge aclk);
		chk(32'(conv_enable), 32'h0);
		u_pm.chan(4'h3);
		u_pm.chan(4'h9);
		rd(REG_STATUS, q);
		chk(32'(q[5:0]), 32'h0000_0011);
		wr(REG_IRQ_STAT, 32'h0000_000F);
		wr(REG_IRQ_MASK, 32'h0000_0001 << IRQ_STEP);
		u_pm.press(1'b1, 10);
		chk(32'(irq), 32'h0);
		u_pm.pos(CAL_OFFSET);
		u_pm.toggles(40, t);
		chk(32'(t inside {[3:5]}), 32'h1);
		u_pm.press(1'b1, 10);
		chk(32'(irq), 32'h1);
		wr(REG_IRQ_STAT, 32'h0000_0001 << IRQ_STEP);
		chk(32'(irq), 32'h0);
		u_pm.pos(CAL_STORE);
		rd(REG_CAL_DATA, q);
		chk(q, {GAIN_RST, OFS_RST});
		wr(REG_CAL_IDX, 32'h0000_0002);
		rd(REG_CAL_DATA, q);
		chk(q, {GAIN_RST, OFS_RST + 16'h0001});
		u_pm.pos(CAL_GAIN);
		u_pm.press(1'b0, HOLD + 1 + REP * 3 + 2);
		u_pm.pos(CAL_STORE);
		rd(REG_CAL_DATA, q);
		t = int'(GAIN_RST - q[31:16]);
		chk(32'(t inside {[4:5]}), 32'h1);
		chk(32'(q[15:0]), 32'h0000_0001);
		u_pm.pos(CAL_GAIN);
		u_pm.press(1'b0, 58000);
		u_pm.toggles(20, t);
		chk(32'(t inside {[4:6]}), 32'h1);
		u_pm.pos(CAL_STORE);
		rd(REG_CAL_DATA, p);
		chk(p, q);
		u_pm.strap(1'b0);
		repeat (4) @(posedge aclk);
		chk(32'(conv_enable), 32'h1);
	endtask

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
		{fault, s_axi_wstrb} = 6'h0F;
		{failures, num_checks} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		s_regs();
		s_normal();
		s_test();
		test_done();
	end
endmodule // apc_cal_panel_tb
